// *** logic/wsc_watchdog.sv ***
// watchdog timer with sleep entry, wake-up sources and status flags
// Summary of operation
// - watchdog counts on own free rc clock
// - timeout while running resets the device
// - timeout while asleep wakes the device
// - any watchdog timeout clears timeout flag
// - config enable low disables watchdog while it stays low
// - option register assigns and divides prescaler
// - kick and sleep clear counter, prescaler
// - kick keeps the prescaler assignment unchanged
// - sleep clears pd, sets to, stops oscillator
// - pins hold pre-sleep state while asleep
// - master clear resets; other events wake
// - pd set at power-up, cleared by sleep
// - only listed peripheral interrupts wake
// - wake needs source enable, not global enable
// - after wake, run next, then maybe vector
// - next address prefetched during sleep instruction
// - pending interrupt makes sleep a no-op
// - interrupt during sleep: finish, then wake
// - 1024-period start-up delay unless rc mode
// - four id locations, program mode only
// - verify read only when unprotected
module wsc_watchdog #(
  parameter int WDT_BASE_TICKS = 18 // base period in rc ticks
) (
  input wire logic sys_clk_i, // system clock, 125 mhz
  input wire logic sys_rst_i, // asynchronous reset, active high
  input wire logic rc_tick_i, // free rc oscillator level, async
  input wire logic master_clear_pin_i, // external reset request, async
  input wire logic kick_instruction_i, // core executes watchdog clear
  input wire logic sleep_instruction_i, // core executes sleep
  input wire logic global_irq_enable_i, // core global enable
  input wire logic [8:0] wake_irq_flag_i, // wake-capable peripheral flags
  input wire logic [8:0] wake_irq_enable_i, // their enable bits
  input wire logic [7:0] config_word_i, // configuration word
  input wire logic program_mode_i, // program/verify mode
  input wire logic [7:0] pin_out_i, // pin drive values from ports
  input wire logic [7:0] pin_oe_i, // pin enables from ports
  input wire logic [13:0] reg_addr_i, // register address
  input wire logic [7:0] reg_wdata_i, // register write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic [7:0] prog_rdata_i, // program word from memory
  output logic [7:0] reg_rdata_o, // read data, cycle after strobe
  output logic device_reset_o, // device reset request, one cycle on a running timeout, held while master clear is high
  output logic core_run_o, // core clock allowed
  output logic osc_drive_o, // oscillator driver on
  output logic irq_vector_o, // branch to 0004h after next instr
  output logic prefetch_o, // fetch pc+1 pulse
  output logic [7:0] pin_out_o, // held pin values
  output logic [7:0] pin_oe_o // held pin enables
);
  import wsc_pkg::*;

  logic rc_s1_q, rc_s2_q, rc_s3_q; // rc synchroniser and edge stage
  logic mc_s1_q, mc_s2_q; // master clear synchroniser
  logic [7:0] option_q; // option register
  logic [7:0] prescale_q; // shared prescaler when on watchdog
  logic [15:0] wdt_q; // watchdog counter
  logic timeout_flag_q; // set means no timeout since clear
  logic powerdown_flag_q; // set means no sleep since power-up
  logic [10:0] ost_q; // start-up counter
  logic [3:0] id_q [0:3]; // id locations, low nibble kept
  logic vec_pend_q; // vector after one instruction
  wsc_state_t state_q;
  logic rc_edge, wdt_en, pre_tick, wdt_timeout, wake_irq, sleep_nop, sleep_do;
  logic [7:0] prescale_mask;
  logic [10:0] start_cnt_q; // check helper: cycles spent in start-up

  // synchronisers: first stage read only by the second
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
      mc_s1_q <= 1'b0;
      mc_s2_q <= 1'b0;
    end else begin
      rc_s1_q <= rc_tick_i;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
      mc_s1_q <= master_clear_pin_i;
      mc_s2_q <= mc_s1_q;
    end
  end

  assign rc_edge = rc_s2_q & ~rc_s3_q;
  assign wdt_en = config_word_i[WSC_CFG_WATCHDOG_CFG_ENABLE_BIT];
  // per-source enable only; only these sources exist
  assign wake_irq = |(wake_irq_flag_i & wake_irq_enable_i);
  // pending interrupt turns sleep into a no-op
  assign sleep_nop = sleep_instruction_i & wake_irq & (state_q == WSC_RUN);
  assign sleep_do = sleep_instruction_i & ~wake_irq & (state_q == WSC_RUN);
  // division 2^(ps+1) when assigned, else direct
  assign prescale_mask = 8'((9'h002 << option_q[2:0]) - 9'h001);
  assign pre_tick = rc_edge & (~option_q[WSC_OPT_PSA_BIT] ||
                               ((prescale_q & prescale_mask) == prescale_mask));
  assign wdt_timeout = wdt_en & pre_tick & (wdt_q == 16'(WDT_BASE_TICKS - 1));

  // option register write
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      option_q <= WSC_OPTION_RST;
    end else if (reg_wr_i && (reg_addr_i == WSC_OFF_OPTION ||
                              reg_addr_i == WSC_OFF_OPTION_HI)) begin
      option_q <= reg_wdata_i;
    end
  end

  // prescaler and watchdog counter
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prescale_q <= 8'h00;
      wdt_q <= 16'h0000;
    end else if (!wdt_en || kick_instruction_i || sleep_do || wdt_timeout) begin
      // kick and executed sleep clear both
      // only the count is cleared, option_q untouched
      prescale_q <= 8'h00;
      wdt_q <= 16'h0000;
    end else if (rc_edge) begin
      prescale_q <= option_q[WSC_OPT_PSA_BIT] ? prescale_q + 8'h01 : 8'h00;
      if (pre_tick) begin
        wdt_q <= wdt_q + 16'h0001;
      end
    end
  end

  // status flags
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      powerdown_flag_q <= 1'b1;
      timeout_flag_q <= 1'b1;
    end else if (wdt_timeout) begin
      // timeout clears to whether reset or wake
      timeout_flag_q <= 1'b0;
    end else if (sleep_do) begin
      // sleep clears pd and sets to
      powerdown_flag_q <= 1'b0;
      timeout_flag_q <= 1'b1;
    end
  end

  // run / sleep / start-up state
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= WSC_RUN;
      ost_q <= 11'h000;
    end else begin
      case (state_q)
        WSC_RUN: begin
          if (sleep_do) begin
            state_q <= WSC_SLEEP;
          end
        end
        WSC_SLEEP: begin
          // timeout wakes; interrupt wakes after full sleep
          if (wdt_timeout || wake_irq) begin
            // start-up delay skipped in rc mode
            if (config_word_i[1:0] == WSC_OSC_RC) begin
              state_q <= WSC_RUN;
            end else begin
              state_q <= WSC_START;
              ost_q <= WSC_OST_CYCLES - 11'h001;
            end
          end
        end
        WSC_START: begin
          if (ost_q == 11'h000) begin
            state_q <= WSC_RUN;
          end else begin
            ost_q <= ost_q - 11'h001;
          end
        end
        default: state_q <= WSC_RUN;
      endcase
    end
  end

  // reset, clock gating and oscillator driver outputs
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      device_reset_o <= 1'b0;
      core_run_o <= 1'b1;
      osc_drive_o <= 1'b1;
      prefetch_o <= 1'b0;
    end else begin
      // running timeout resets; master clear always resets
      device_reset_o <= (wdt_timeout && state_q == WSC_RUN) || mc_s2_q;
      core_run_o <= (state_q == WSC_RUN) && !sleep_do;
      osc_drive_o <= (state_q != WSC_SLEEP) && !sleep_do;
      prefetch_o <= sleep_do | sleep_nop;
    end
  end

  // vector request after interrupt wake
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vec_pend_q <= 1'b0;
      irq_vector_o <= 1'b0;
    end else begin
      // one in-line instruction, then vector if enabled
      if (state_q == WSC_SLEEP && wake_irq && global_irq_enable_i) begin
        vec_pend_q <= 1'b1;
      end else if (vec_pend_q && state_q == WSC_RUN) begin
        vec_pend_q <= 1'b0;
      end
      irq_vector_o <= vec_pend_q && state_q == WSC_RUN;
    end
  end

  // pin hold
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_out_o <= 8'h00;
      pin_oe_o <= 8'h00;
    end else if (state_q == WSC_RUN && !sleep_do) begin
      // frozen outside run, pre-sleep values kept
      pin_out_o <= pin_out_i;
      pin_oe_o <= pin_oe_i;
    end
  end

  // id locations, one per entry
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_id
      always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          id_q[gi] <= 4'h0;
        end else if (reg_wr_i && program_mode_i &&
                     reg_addr_i == WSC_OFF_ID_BASE + 14'(gi)) begin
          id_q[gi] <= reg_wdata_i[3:0];
        end
      end
    end
  endgenerate

  // read data, valid the cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= WSC_PROG_WORD_RST;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_addr_i == WSC_OFF_OPTION || reg_addr_i == WSC_OFF_OPTION_HI) begin
      reg_rdata_o <= option_q;
    end else if (reg_addr_i == WSC_OFF_CONFIG) begin
      reg_rdata_o <= config_word_i;
    end else if (reg_addr_i == WSC_OFF_STATUS) begin
      reg_rdata_o <= {3'h0, timeout_flag_q, powerdown_flag_q, 3'h0};
    end else if (program_mode_i && reg_addr_i >= WSC_OFF_ID_BASE &&
                 reg_addr_i <= WSC_OFF_ID_LAST) begin
      // id readable only in program mode
      reg_rdata_o <= {4'h0, id_q[reg_addr_i[1:0]]};
    end else if (program_mode_i && reg_addr_i == WSC_OFF_PROG &&
                 config_word_i[WSC_CFG_CP_LSB +: 2] == WSC_CP_NONE) begin
      reg_rdata_o <= prog_rdata_i;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // check helper: counts start-up cycles so a long bound needs no wide delay range
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      start_cnt_q <= 11'h000;
    end else if (state_q == WSC_START) begin
      start_cnt_q <= start_cnt_q + 11'h001;
    end else begin
      start_cnt_q <= 11'h000;
    end
  end

  // checks
  sequence s_sleep_exec;
    sleep_do && !wdt_timeout;
  endsequence
  // a timeout in the same cycle wins over sleep on the flags, so it is left out here
  chk_sleep_flags: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    s_sleep_exec |=> !powerdown_flag_q && timeout_flag_q)
    else $error("pd not cleared by sleep");
  chk_run_reset: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wdt_timeout && state_q == WSC_RUN) |=> device_reset_o)
    else $error("running timeout gave no reset");
  chk_sleep_wake: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wdt_timeout && state_q == WSC_SLEEP) |=> state_q != WSC_SLEEP && !device_reset_o)
    else $error("sleeping timeout did not wake");
  chk_to_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wdt_timeout |=> !timeout_flag_q)
    else $error("timeout flag not cleared");
  chk_wdt_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !wdt_en |=> wdt_q == 16'h0000)
    else $error("disabled watchdog counted");
  chk_kick_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    kick_instruction_i |=> wdt_q == 16'h0000 && prescale_q == 8'h00 && $stable(option_q))
    else $error("kick did not clear watchdog");
  chk_nop_sleep: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    sleep_nop && !wdt_timeout |=> $stable(powerdown_flag_q) && state_q == WSC_RUN)
    else $error("sleep not a no-op with pending irq");
  chk_ost_delay: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state_q == WSC_START |-> start_cnt_q < 11'(WSC_TOST_TOSC))
    else $error("start-up delay too long");
  chk_pin_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state_q == WSC_SLEEP |=> $stable(pin_out_o) && $stable(pin_oe_o))
    else $error("pins changed in sleep");
endmodule : wsc_watchdog

// *** logic/wsc_pkg.sv ***
// package of constants and types for the watchdog and sleep/wake controller
package wsc_pkg;
  // register offsets on the plain register port
  localparam logic [13:0] WSC_OFF_OPTION = 14'h0081; // option register, bank 0 alias
  localparam logic [13:0] WSC_OFF_OPTION_HI = 14'h0181; // option register, bank 2 alias
  localparam logic [13:0] WSC_OFF_CONFIG = 14'h2007; // configuration word, read only
  localparam logic [13:0] WSC_OFF_STATUS = 14'h0003; // status flags, read only here
  localparam logic [13:0] WSC_OFF_ID_BASE = 14'h2000; // first of four id locations
  localparam logic [13:0] WSC_OFF_ID_LAST = 14'h2003; // last id location
  localparam logic [13:0] WSC_OFF_PROG = 14'h0100; // program memory verify read port
  // option register fields
  localparam int WSC_OPT_PSA_BIT = 3; // prescaler_assign, 1 = watchdog
  localparam int WSC_OPT_PS_LSB = 0; // prescale_select_lo position
  localparam logic [7:0] WSC_OPTION_RST = 8'hFF; // option register after reset
  // configuration word fields
  localparam int WSC_CFG_WATCHDOG_CFG_ENABLE_BIT = 2; // watchdog_cfg_enable
  localparam int WSC_CFG_CP_LSB = 4; // code_protect_lo, code_protect_hi above it
  localparam int WSC_CFG_OSC_LSB = 0; // osc_select field
  localparam logic [1:0] WSC_OSC_RC = 2'h3; // rc oscillator mode
  localparam logic [1:0] WSC_CP_NONE = 2'h3; // unprogrammed protection bits
  // status bit positions
  localparam int WSC_ST_PD_BIT = 3; // powerdown_flag
  localparam int WSC_ST_TO_BIT = 4; // timeout_flag
  // timing
  localparam int WSC_TOST_TOSC = 1024; // oscillator start-up periods
  localparam int WSC_CLK_MHZ = 125; // system clock rate
  localparam logic [10:0] WSC_OST_CYCLES = 11'(WSC_TOST_TOSC); // one tosc per clock here
  localparam logic [7:0] WSC_PROG_WORD_RST = 8'h00; // reset value of small storage
  // sleep/run state
  typedef enum logic [1:0] {
    WSC_RUN = 2'b00,
    WSC_SLEEP = 2'b01,
    WSC_START = 2'b10
  } wsc_state_t;
endpackage : wsc_pkg

// *** bench/wsc_core_model.sv ***
// model of the processor core and the free rc oscillator beside the watchdog block
module wsc_core_model (
  input wire logic sys_clk_i, // core clock
  output logic rc_tick_o, // free rc oscillator square wave
  output logic kick_o, // watchdog clear instruction pulse
  output logic sleep_o // sleep instruction pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // all idle at time zero
  initial begin
    rc_tick_o = 1'b0;
    kick_o = 1'b0;
    sleep_o = 1'b0;
  end
  // own rc clock
  // period 40 ns, five core clock periods, so rc edges keep a fixed phase to the core clock
  always #20 rc_tick_o = ~rc_tick_o;
  // one-cycle sleep instruction, changed just after an edge
  task exec_sleep();
    @(posedge sys_clk_i);
    sleep_o <= 1'b1;
    @(posedge sys_clk_i);
    sleep_o <= 1'b0;
  endtask : exec_sleep
  // one-cycle watchdog clear instruction
  task exec_kick();
    @(posedge sys_clk_i);
    kick_o <= 1'b1;
    @(posedge sys_clk_i);
    kick_o <= 1'b0;
  endtask : exec_kick
endmodule : wsc_core_model

// *** bench/watchdog_sleep_wake_control_bench.sv ***
// self-checking bench of the watchdog and sleep/wake controller
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module watchdog_sleep_wake_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import wsc_pkg::*;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, rc_tick, kick, slp, master_clear_pin = 1'b0, global_irq_enable = 1'b0;
  logic [8:0] flg = '0, ena = '0; // wake sources
  logic [7:0] cfg = 8'h33, pout = 8'hA5, poe = 8'h0F, wdat = 8'h00, prd = 8'h3C;
  logic [7:0] rdat, pin_o, oe_o, d;
  logic [13:0] addr = 14'h0000;
  logic wr = 1'b0, rd = 1'b0, pmode = 1'b0, drst, run, osc, vec, pf;
  int miscompares = 0, n_compared = 0, n_rst = 0, n_vec = 0, n, m;
  always #4 sys_clk_i = ~sys_clk_i;
  // partner core; short base period keeps timeouts within tens of cycles
  wsc_core_model core (.sys_clk_i(sys_clk_i), .rc_tick_o(rc_tick), .kick_o(kick), .sleep_o(slp));
  wsc_watchdog #(.WDT_BASE_TICKS(4)) uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .rc_tick_i(rc_tick), .master_clear_pin_i(master_clear_pin), .kick_instruction_i(kick),
    .sleep_instruction_i(slp), .global_irq_enable_i(global_irq_enable), .wake_irq_flag_i(flg),
    .wake_irq_enable_i(ena), .config_word_i(cfg), .program_mode_i(pmode), .pin_out_i(pout),
    .pin_oe_i(poe), .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd),
    .prog_rdata_i(prd), .reg_rdata_o(rdat), .device_reset_o(drst), .core_run_o(run),
    .osc_drive_o(osc), .irq_vector_o(vec), .prefetch_o(pf), .pin_out_o(pin_o), .pin_oe_o(oe_o));
  // pulse counters, sampled mid-cycle where registered outputs have settled
  always @(negedge sys_clk_i) begin
    if (drst === 1'b1) n_rst++;
    if (vec === 1'b1) n_vec++;
  end
  task wr_reg(input logic [13:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    addr <= a;
    wdat <= v;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task chk_rd(input logic [13:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    @(negedge sys_clk_i);
    `CHK(rdat & mask, exp)
  endtask : chk_rd
  // bounded wait for the core clock to come back
  task wait_run(input int lim);
    n = 0;
    while (run !== 1'b1 && n < lim) begin
      @(negedge sys_clk_i);
      n++;
    end
  endtask : wait_run
  task sleep_chk();
    core.exec_sleep();
    @(negedge sys_clk_i);
    `CHK({run, osc, pf}, 3'b001)
  endtask : sleep_chk
  task irq_wake(input int i);
    @(posedge sys_clk_i);
    flg[i] <= 1'b1;
    ena[i] <= 1'b1;
    wait_run(40);
    `CHK(run, 1'b1)
    @(posedge sys_clk_i);
    flg <= '0;
    ena <= '0;
  endtask : irq_wake
  task test_done();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // hang guard, well past the few thousand cycles the sequence needs
  initial begin
    #300us;
    miscompares++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    chk_rd(WSC_OFF_OPTION, 8'hFF, WSC_OPTION_RST);
    chk_rd(WSC_OFF_OPTION_HI, 8'hFF, WSC_OPTION_RST);
    chk_rd(WSC_OFF_STATUS, 8'h18, 8'h18);
    chk_rd(WSC_OFF_CONFIG, 8'hFF, 8'h33);
    chk_rd(14'h0055, 8'hFF, 8'h00);
    // id reads are closed outside program mode, verify reads under code protection
    chk_rd(WSC_OFF_ID_BASE, 8'hFF, 8'h00);
    pmode <= 1'b1;
    wr_reg(WSC_OFF_ID_LAST, 8'h07);
    chk_rd(WSC_OFF_ID_LAST, 8'h0F, 8'h07);
    chk_rd(WSC_OFF_PROG, 8'hFF, 8'h3C);
    cfg <= 8'h03;
    chk_rd(WSC_OFF_PROG, 8'hFF, 8'h00);
    cfg <= 8'h33;
    pmode <= 1'b0;
    // pending enabled interrupt turns sleep into a no-op
    @(posedge sys_clk_i);
    flg[3] <= 1'b1;
    ena[3] <= 1'b1;
    core.exec_sleep();
    @(negedge sys_clk_i);
    `CHK(run, 1'b1)
    chk_rd(WSC_OFF_STATUS, 8'h18, 8'h18);
    @(posedge sys_clk_i);
    flg <= '0;
    ena <= '0;
    // real sleep: flags, frozen pins, disabled source ignored
    sleep_chk();
    @(posedge sys_clk_i);
    pout <= 8'h5A;
    poe <= 8'hF0;
    flg[0] <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    `CHK({pin_o, oe_o}, 16'hA50F)
    `CHK(run, 1'b0)
    chk_rd(WSC_OFF_STATUS, 8'h18, 8'h10);
    // every wake-capable source, global enable off: no vector
    for (int i = 0; i < 9; i++) begin
      if (i > 0) sleep_chk();
      irq_wake(i);
    end
    repeat (4) @(posedge sys_clk_i);
    `CHK(n_vec, 0)
    global_irq_enable <= 1'b1;
    sleep_chk();
    irq_wake(2);
    repeat (4) @(posedge sys_clk_i);
    `CHK(n_vec, 1)
    global_irq_enable <= 1'b0;
    // crystal mode wake waits out the start-up delay
    cfg <= 8'h30;
    sleep_chk();
    @(posedge sys_clk_i);
    flg[5] <= 1'b1;
    ena[5] <= 1'b1;
    wait_run(1100);
    `CHK(n inside {[WSC_TOST_TOSC - 4 : WSC_TOST_TOSC + 16]}, 1'b1)
    flg <= '0;
    ena <= '0;
    cfg <= 8'h33;
    repeat (100) @(posedge sys_clk_i);
    `CHK(n_rst, 0)
    // enabled watchdog, no prescaler: kicks hold it off, silence resets
    cfg <= 8'h37;
    wr_reg(WSC_OFF_OPTION, 8'h00);
    repeat (20) begin
      core.exec_kick();
      repeat (6) @(posedge sys_clk_i);
    end
    `CHK(n_rst, 0)
    for (n = 0; n < 60 && n_rst == 0; n++) @(negedge sys_clk_i);
    `CHK(n_rst, 1)
    // prescaler by 4 on the watchdog stretches the period; kick keeps assignment
    wr_reg(WSC_OFF_OPTION, 8'h09);
    core.exec_kick();
    m = n_rst;
    chk_rd(WSC_OFF_OPTION, 8'hFF, 8'h09);
    repeat (35) @(posedge sys_clk_i);
    `CHK(n_rst, m)
    for (n = 0; n < 150 && n_rst == m; n++) @(negedge sys_clk_i);
    `CHK(n_rst, m + 1)
    // timeout while asleep wakes instead of resetting
    wr_reg(WSC_OFF_OPTION, 8'h00);
    sleep_chk();
    m = n_rst;
    wait_run(80);
    `CHK(run, 1'b1)
    `CHK(n_rst, m)
    chk_rd(WSC_OFF_STATUS, 8'h10, 8'h00);
    // master clear during sleep is a device reset
    cfg <= 8'h33;
    sleep_chk();
    m = n_rst;
    @(posedge sys_clk_i);
    master_clear_pin <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    master_clear_pin <= 1'b0;
    `CHK(n_rst > m, 1'b1)
    test_done();
  end
endmodule : watchdog_sleep_wake_control_bench
